// *** design/pbsram_pkg.sv ***
package pbsram_pkg;
  // ---------------------------------------------------------------
  // array geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int DEPTH = 65536;
  // ---------------------------------------------------------------
  // reset values and burst constants
  // ---------------------------------------------------------------
  localparam logic [1:0] BURST_ONE = 2'h1;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [31:0] DATA_RST = 32'h00000000;
  // clock_to_output_time: data leaves the output register one edge on
  localparam int CLK_PERIOD_NS = 100;
  localparam int READ_LATENCY_CYC = 1;

  typedef enum logic [1:0] {
    PBSR_DESEL,
    PBSR_READ,
    PBSR_WRITE,
    PBSR_SLEEP
  } pbsr_state_t;
endpackage : pbsram_pkg

// *** design/pbsram_core.sv ***
`timescale 1ns/1ps
module pbsram_core
  import pbsram_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [pbsram_pkg::ADDR_W-1:0] ADDR,
  input wire logic CPU_ADDR_STROBE_N,
  input wire logic CTRL_ADDR_STROBE_N,
  input wire logic BURST_STEP_N,
  input wire logic CHIP_SEL1_N,
  input wire logic CHIP_SEL2,
  input wire logic CHIP_SEL3_N,
  input wire logic ALL_BYTE_WRITE_N,
  input wire logic BYTE_WRITE_QUALIFY_N,
  input wire logic [pbsram_pkg::LANES-1:0] BYTE_LANE_SEL_N,
  input wire logic OUT_ENABLE_N,
  input wire logic SLEEP_REQ,
  input wire logic BURST_ORDER_SEL,
  input wire logic [pbsram_pkg::DATA_W-1:0] DATA_IN,
  output logic [pbsram_pkg::DATA_W-1:0] DATA_OUT,
  output logic [pbsram_pkg::DATA_W-1:0] DATA_OE,
  output logic SLEEPING
);
  import pbsram_pkg::*;

  // ---------------------------------------------------------------
  // pipeline overview
  // ---------------------------------------------------------------
  // edge 0: pins land in the input flops
  // edge 1: a recognized strobe loads address and burst start
  // edge 1: a controller write registers address, data and lanes
  // edge 2: read data leaves the output register
  // edge 2: the registered write reaches the array
  // output enable is flopped too, so it acts one edge late
  // sleep blocks strobes and drops writes already in flight
  // chip selects are looked at only with a recognized strobe
  // limitation: the array has no reset and wakes with unknown data

  // ---------------------------------------------------------------
  // input registers
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] addr_ff;
  logic cpu_stb_ff;
  logic ctrl_stb_ff;
  logic step_ff;
  logic cs1_ff;
  logic cs2_ff;
  logic cs3_ff;
  logic gw_ff;
  logic bwe_ff;
  logic [LANES-1:0] bw_ff;
  logic oe_ff;
  logic sleep_ff;
  logic mode_ff;
  logic [DATA_W-1:0] din_ff;

  // every synchronous input passes one flop first
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      addr_ff <= ADDR_RST;
      cpu_stb_ff <= 1'b1;
      ctrl_stb_ff <= 1'b1;
      step_ff <= 1'b1;
      cs1_ff <= 1'b1;
      cs2_ff <= 1'b0;
      cs3_ff <= 1'b1;
      gw_ff <= 1'b1;
      bwe_ff <= 1'b1;
      bw_ff <= 4'hF;
      oe_ff <= 1'b1;
      sleep_ff <= 1'b0;
      mode_ff <= 1'b1;
      din_ff <= DATA_RST;
    end
    else
    begin
      addr_ff <= ADDR;
      cpu_stb_ff <= CPU_ADDR_STROBE_N;
      ctrl_stb_ff <= CTRL_ADDR_STROBE_N;
      step_ff <= BURST_STEP_N;
      cs1_ff <= CHIP_SEL1_N;
      cs2_ff <= CHIP_SEL2;
      cs3_ff <= CHIP_SEL3_N;
      gw_ff <= ALL_BYTE_WRITE_N;
      bwe_ff <= BYTE_WRITE_QUALIFY_N;
      bw_ff <= BYTE_LANE_SEL_N;
      oe_ff <= OUT_ENABLE_N;
      sleep_ff <= SLEEP_REQ;
      mode_ff <= BURST_ORDER_SEL;
      din_ff <= DATA_IN;
    end
  end

  // ---------------------------------------------------------------
  // strobe decode
  // ---------------------------------------------------------------
  logic cpu_rec;
  logic ctrl_rec;
  logic strobe_rec;
  logic sel_ok;
  logic wr_req;
  logic [LANES-1:0] lane_we;

  // processor strobe wins when both are low; ignored with cs1 high
  always_comb
  begin
    cpu_rec = !cpu_stb_ff && !cs1_ff;
    ctrl_rec = !ctrl_stb_ff && cpu_stb_ff;
    strobe_rec = (cpu_rec || ctrl_rec) && !sleep_ff;
    sel_ok = !cs1_ff && cs2_ff && !cs3_ff;
    wr_req = !gw_ff || !bwe_ff;
    if (!gw_ff)
      lane_we = 4'hF;
    else if (!bwe_ff)
      lane_we = ~bw_ff;
    else
      lane_we = 4'h0;
  end

  // ---------------------------------------------------------------
  // burst counter
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] base_ff;
  logic [1:0] start_ff;
  logic [1:0] step_cnt_ff;
  logic [1:0] nxt_step_cnt;

  // burst low bits for a given start and step count
  function automatic logic [1:0] burst_low(input logic [1:0] start,
                                           input logic [1:0] cnt,
                                           input logic linear_n);
    if (linear_n)
      burst_low = start ^ cnt;
    else
      burst_low = 2'(start + cnt);
  endfunction : burst_low

  // true while an access owns the counter and the array
  function automatic logic is_active(input pbsr_state_t st);
    is_active = (st == PBSR_READ) || (st == PBSR_WRITE);
  endfunction : is_active

  // counter is two bits, so it wraps without touching upper bits
  always_comb
  begin
    if (!step_ff)
      nxt_step_cnt = 2'(step_cnt_ff + BURST_ONE);
    else
      nxt_step_cnt = step_cnt_ff;
  end

  pbsr_state_t state_ff;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      base_ff <= ADDR_RST;
      start_ff <= 2'h0;
      step_cnt_ff <= 2'h0;
    end
    else if (strobe_rec && sel_ok)
    begin
      base_ff <= addr_ff;
      start_ff <= addr_ff[1:0];
      step_cnt_ff <= 2'h0;
    end
    else if (is_active(state_ff))
      step_cnt_ff <= nxt_step_cnt;
  end

  logic [ADDR_W-1:0] cur_addr;
  assign cur_addr = {base_ff[ADDR_W-1:2],
                     burst_low(start_ff, step_cnt_ff, mode_ff)};

  // ---------------------------------------------------------------
  // access state
  // ---------------------------------------------------------------
  logic fresh_ff;

  // a recognized strobe with selects inactive deselects; cs ignored inside a burst
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      state_ff <= PBSR_DESEL;
      fresh_ff <= 1'b0;
    end
    else if (sleep_ff)
    begin
      state_ff <= PBSR_SLEEP;
      fresh_ff <= 1'b0;
    end
    else if (strobe_rec)
    begin
      if (!sel_ok)
      begin
        state_ff <= PBSR_DESEL;
        fresh_ff <= 1'b0;
      end
      else
      begin
        // cpu strobe cycles are reads first; writes come on later edges
        state_ff <= (ctrl_rec && wr_req) ? PBSR_WRITE : PBSR_READ;
        fresh_ff <= (state_ff == PBSR_DESEL || state_ff == PBSR_SLEEP);
      end
    end
    else
    begin
      case (state_ff)
        PBSR_DESEL: state_ff <= PBSR_DESEL;
        PBSR_SLEEP: state_ff <= PBSR_DESEL;
        PBSR_READ: state_ff <= wr_req ? PBSR_WRITE : PBSR_READ;
        PBSR_WRITE: state_ff <= wr_req ? PBSR_WRITE : PBSR_READ;
        default: state_ff <= PBSR_DESEL;
      endcase
      fresh_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // write capture
  // ---------------------------------------------------------------
  logic in_burst;
  logic wr_now;
  logic [ADDR_W-1:0] wr_addr_sel;

  // controller strobe writes from the flopped pins of its own cycle;
  // a processor strobe ignores write controls until the next cycle
  always_comb
  begin
    in_burst = is_active(state_ff);
    if (sleep_ff)
      wr_now = 1'b0; // writes in flight are dropped on sleep entry
    else if (strobe_rec)
      wr_now = sel_ok && ctrl_rec;
    else
      wr_now = in_burst;
    // the address register is not loaded yet on the strobe edge
    if (strobe_rec && sel_ok)
      wr_addr_sel = addr_ff;
    else
      wr_addr_sel = cur_addr;
  end

  // ---------------------------------------------------------------
  // array and output register
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] wr_addr_ff;
  logic [DATA_W-1:0] wr_data_ff;
  logic [LANES-1:0] wr_lane_ff;

  // write path: a write cycle registers address, data and lanes
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      wr_addr_ff <= ADDR_RST;
      wr_data_ff <= DATA_RST;
      wr_lane_ff <= 4'h0;
    end
    else
    begin
      // address, data and lanes all come from one and the same cycle
      wr_addr_ff <= wr_addr_sel;
      wr_data_ff <= din_ff;
      wr_lane_ff <= wr_now ? lane_we : 4'h0;
    end
  end

  // array has no reset; contents survive sleep and reset alike
  always_ff @(posedge CLK)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      if (wr_lane_ff[i])
        mem[wr_addr_ff][i*LANE_W +: LANE_W] <=
          wr_data_ff[i*LANE_W +: LANE_W];
    end
  end

  // output register holds data of the address seen one edge earlier
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      DATA_OUT <= DATA_RST;
    else if (state_ff == PBSR_READ)
      DATA_OUT <= mem[cur_addr];
  end

  // ---------------------------------------------------------------
  // output enable and status
  // ---------------------------------------------------------------
  logic drive;
  // out_enable_n is sampled, a limit of having one clock only
  // sleep entry releases the pins on the same edge as the status
  assign drive = (state_ff == PBSR_READ) && !fresh_ff && !oe_ff &&
                 !sleep_ff &&
                 !(strobe_rec && !sel_ok);

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      DATA_OE <= DATA_RST;
      SLEEPING <= 1'b0;
    end
    else
    begin
      DATA_OE <= {DATA_W{drive}};
      SLEEPING <= sleep_ff;
    end
  end
endmodule : pbsram_core

// *** tb/pbsram_props.sv ***
`timescale 1ns/1ps
module pbsram_props
  import pbsram_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic CPU_ADDR_STROBE_N,
  input wire logic CTRL_ADDR_STROBE_N,
  input wire logic BURST_STEP_N,
  input wire logic CHIP_SEL1_N,
  input wire logic CHIP_SEL2,
  input wire logic CHIP_SEL3_N,
  input wire logic ALL_BYTE_WRITE_N,
  input wire logic BYTE_WRITE_QUALIFY_N,
  input wire logic OUT_ENABLE_N,
  input wire logic SLEEP_REQ,
  input wire logic [pbsram_pkg::DATA_W-1:0] DATA_OUT,
  input wire logic [pbsram_pkg::DATA_W-1:0] DATA_OE,
  input wire logic SLEEPING
);
  logic sel, acc, rd, dsel, act, desel_ff;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // decoded strobe kinds, as the device should see them
  assign sel = !CHIP_SEL1_N && CHIP_SEL2 && !CHIP_SEL3_N;
  assign acc = sel && (!CPU_ADDR_STROBE_N || !CTRL_ADDR_STROBE_N);
  assign rd = acc && ALL_BYTE_WRITE_N && BYTE_WRITE_QUALIFY_N;
  assign dsel = !CTRL_ADDR_STROBE_N && CPU_ADDR_STROBE_N && !sel;
  assign act = !CPU_ADDR_STROBE_N || !CTRL_ADDR_STROBE_N || !BURST_STEP_N;
  // tracks whether the next access emerges from deselect
  always_ff @(posedge CLK or posedge RST)
    if (RST)
      desel_ff <= 1'b1;
    else if (acc)
      desel_ff <= 1'b0;
    else if (dsel || SLEEPING)
      desel_ff <= 1'b1;
  sleep_quiet_a: assert property (SLEEPING |-> DATA_OE == '0)
    else $error("pins driven while asleep");
  oe_masked_a: assert property (OUT_ENABLE_N [*4] |-> DATA_OE == '0)
    else $error("pins driven with output enable off");
  desel_float_a: assert property (dsel |-> ##3 DATA_OE == '0)
    else $error("pins still driven after deselect");
  first_float_a: assert property (rd && desel_ff |-> ##3 DATA_OE == '0)
    else $error("first read cycle after deselect drove pins");
  b2b_drive_a: assert property ((rd && !OUT_ENABLE_N) ##1
    (rd && !OUT_ENABLE_N) |-> ##3 DATA_OE == '1)
    else $error("back to back read not driven");
  hold_data_a: assert property ($changed(DATA_OUT) |->
    $past(act, 2) || $past(act, 3) || $past(act, 4))
    else $error("read data changed without strobe or step");
  sleep_enter_a: assert property (SLEEP_REQ [*3] |-> SLEEPING)
    else $error("sleep not entered");
  sleep_exit_a: assert property (!SLEEP_REQ [*3] |-> !SLEEPING)
    else $error("sleep not left");
endmodule : pbsram_props
bind pbsram_core pbsram_props pbsram_props_i (.*);

// *** tb/pbsr_far_bus.sv ***
`timescale 1ns/1ps
module pbsr_far_bus
  import pbsram_pkg::*;
(
  input wire logic [pbsram_pkg::DATA_W-1:0] dout,
  input wire logic [pbsram_pkg::DATA_W-1:0] oe,
  input wire logic [pbsram_pkg::DATA_W-1:0] host_d,
  input wire logic host_oe,
  output logic [pbsram_pkg::DATA_W-1:0] din
);
  // a released bit reads as the inverse, never a stale match
  always_comb
    for (int i = 0; i < DATA_W; i++)
      din[i] = oe[i] ? dout[i] : (host_oe ? host_d[i] : ~host_d[i]);
endmodule : pbsr_far_bus

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`define CHK(a, b) \
  n_tests++; \
  if ((a) !== (b)) \
  begin \
    errors++; \
    $display("unexpected t=%0t got %h want %h", $time, a, b); \
  end
module testbench;
  import pbsram_pkg::*;
  logic clk = 0, rst = 1, cpu_n = 1, ctrl_n = 1, step_n = 1, cs1_n = 0;
  logic cs2 = 1, cs3_n = 0, gw_n = 1, bwe_n = 1, oe_n = 1, slp = 0;
  logic mode = 1, host_oe = 0, sleeping;
  logic [3:0] lane_n = 4'hF;
  logic [15:0] addr = 16'h0000;
  logic [31:0] host_d = 32'h00000000, din, dout, doe, m [4];
  int errors = 0, n_tests = 0;
  // free running 10 MHz clock
  initial
    forever #50 clk = ~clk;
  pbsram_core pbsram_core_i (
    .CLK(clk), .RST(rst), .ADDR(addr),
    .CPU_ADDR_STROBE_N(cpu_n), .CTRL_ADDR_STROBE_N(ctrl_n),
    .BURST_STEP_N(step_n), .CHIP_SEL1_N(cs1_n), .CHIP_SEL2(cs2),
    .CHIP_SEL3_N(cs3_n), .ALL_BYTE_WRITE_N(gw_n),
    .BYTE_WRITE_QUALIFY_N(bwe_n), .BYTE_LANE_SEL_N(lane_n),
    .OUT_ENABLE_N(oe_n), .SLEEP_REQ(slp), .BURST_ORDER_SEL(mode),
    .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe), .SLEEPING(sleeping));
  pbsr_far_bus pbsr_far_bus_i (.dout(dout), .oe(doe), .host_d(host_d),
    .host_oe(host_oe), .din(din));
  task automatic reset(input logic md);
    rst = 1;
    mode = md; // strap moves only under reset
    repeat (20) @(negedge clk);
    rst = 0;
  endtask : reset
  // c = {cpu_n, ctrl_n, gw_n}; strobe stays until the caller idles
  task automatic go(input logic [2:0] c, input logic [15:0] a);
    {cpu_n, ctrl_n, gw_n} = c;
    addr = a;
    @(negedge clk);
  endtask : go
  task automatic idle(input int n);
    {cpu_n, ctrl_n, gw_n, step_n} = 4'hF;
    host_oe = 0;
    repeat (n) @(negedge clk);
  endtask : idle
  task automatic desel();
    cs2 = 0;
    go(3'h5, 16'h0000);
    idle(2);
    `CHK(doe, '0)
    cs2 = 1;
  endtask : desel
  task automatic s_write();
    oe_n = 1;
    host_oe = 1;
    for (int i = 0; i < 4; i++)
    begin
      m[i] = {16'hA5C3, 16'h0120 + i[15:0]};
      host_d = m[i];
      go(3'h4, 16'h0120 + i[15:0]);
    end
    {bwe_n, lane_n, host_d} = {1'b0, 4'hA, 32'h11223344};
    go(3'h5, 16'h0121); // lanes 0 and 2 only
    {lane_n, host_d} = {4'hF, 32'h55667788};
    go(3'h4, 16'h0123); // global write overrides lanes
    {bwe_n, host_d} = {1'b1, 32'hDEAD0000};
    go(3'h0, 16'h0122); // both strobes: processor cycle
    cs1_n = 1;
    go(3'h3, 16'h0120); // ignored processor strobe, no write
    idle(3);
    cs1_n = 0;
    m[1] = 32'hA5220144;
    m[3] = 32'h55667788;
  endtask : s_write
  task automatic s_burst(input logic md, input logic [1:0] st);
    logic [1:0] k;
    reset(md);
    oe_n = 0;
    go(3'h5, {14'h0048, st});
    {ctrl_n, step_n} = 2'b10;
    @(negedge clk);
    for (int j = 0; j < 6; j++)
    begin
      @(negedge clk);
      k = (j > 4) ? st : (md ? (st ^ j[1:0]) : (st + j[1:0]));
      `CHK(dout, m[k])
      if (j == 0)
      begin
        `CHK(doe, '0)
      end
      if (j == 2)
        step_n = 1;
      if (j == 5)
      begin
        `CHK(doe, '1)
      end
    end
    desel();
  endtask : s_burst
  task automatic s_b2b();
    go(3'h5, 16'h0122);
    go(3'h5, 16'h0123);
    idle(1);
    `CHK(dout, m[2])
    @(negedge clk);
    `CHK(dout, m[3])
    `CHK(doe, '1)
  endtask : s_b2b
  task automatic s_sleep();
    desel();
    slp = 1;
    repeat (4) @(negedge clk);
    `CHK(sleeping, 1'b1)
    slp = 0;
    repeat (4) @(negedge clk);
    `CHK(sleeping, 1'b0)
    go(3'h5, 16'h0120);
    idle(3);
    `CHK(dout, m[0])
  endtask : s_sleep
  task automatic results();
    $display("errors=%0d comparisons=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  // main sequence
  initial
  begin
    reset(1);
    s_write();
    s_burst(0, 2'h1);
    s_burst(1, 2'h1);
    s_burst(1, 2'h2);
    s_b2b();
    s_sleep();
    results();
  end
endmodule : testbench
